// *** common/fpuc_pkg.sv ***
// Constants, command codes and controller states for the flash protect and unlock controller.
package fpuc_pkg;

    // ----------------------------------------
    // Register file addresses
    // ----------------------------------------
    localparam logic [11:0] ADDR_CMD = 12'hff8;
    localparam logic [11:0] ADDR_PAGE = 12'hff9;
    localparam logic [11:0] ADDR_FREQ_HI = 12'hffa;
    localparam logic [11:0] ADDR_FREQ_LO = 12'hffb;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] CMD_SECT_SEL = 8'h5e;

    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int PAGE_BYTES = 512;
    localparam int PAGE_LSB = 9;
    localparam int INFO_EN_BIT = 7;
    localparam logic [6:0] INFO_PAGE = 7'h7f;
    localparam logic [8:0] PART_ID_BASE = 9'h040;
    localparam logic [8:0] PART_ID_LEN = 9'h014;
    localparam logic [6:0] PAGES_LARGE = 7'h10;
    localparam logic [6:0] PAGES_SMALL = 7'h08;
    localparam int SECT_LSB_LARGE = 10;
    localparam int SECT_LSB_SMALL = 9;

    // ----------------------------------------
    // Clock and timing figures
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam logic [15:0] FREQ_MIN_KHZ = 16'h0014;
    localparam logic [15:0] FREQ_MAX_KHZ = 16'h4e20;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] PROT_RST = 8'h00;
    localparam logic [7:0] FREQ_RST = 8'h00;

    // ----------------------------------------
    // Controller states; low codes are the reported status
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_LOCK = 3'b000,
        ST_UNLK1 = 3'b001,
        ST_UNLK2 = 3'b010,
        ST_OPEN = 3'b011,
        ST_SECT = 3'b100,
        ST_ARMED = 3'b101,
        ST_PAGED = 3'b110
    } fpuc_state_t;

endpackage : fpuc_pkg

// *** verilog/fpuc_info_rom.sv ***
// Read-only information area holding the part identifier string.
`timescale 1ns/1ps
module fpuc_info_rom
    import fpuc_pkg::*;
#(
    // Arbitrary neutral identifier, twelve characters then zero padding.
    parameter logic [159:0] PART_ID = {"NEUTRAL-ID-0", 64'h0}
)
(
    input wire logic [8:0] addr,
    output logic [7:0] data
);

    logic [8:0] idx;
    logic [159:0] shifted;

    // ----------------------------------------
    // Identifier lookup
    // ----------------------------------------
    // Bytes outside the identifier window read as zero, like the reserved space.
    always_comb
    begin
        idx = addr - PART_ID_BASE;
        shifted = PART_ID << {idx, 3'b000};
        data = 8'h00;
        if (addr >= PART_ID_BASE && idx < PART_ID_LEN)
        begin
            data = shifted[159:152]; // [RULE7]
        end
    end

endmodule : fpuc_info_rom

// *** verilog/fpuc_sector_map.sv ***
// Maps a flash address onto its sector and checks range and protection.
`timescale 1ns/1ps
module fpuc_sector_map
    import fpuc_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic flash_8k,
    input wire logic [7:0] protect,
    output logic [2:0] sector,
    output logic in_range,
    output logic prot_hit
);

    // ----------------------------------------
    // Sector decode
    // ----------------------------------------
    // Eight equal sectors in either size; the sector field moves by one bit.
    always_comb
    begin
        if (flash_8k)
        begin
            sector = addr[SECT_LSB_LARGE +: 3]; // [RULE3]
            in_range = addr[15:PAGE_LSB] < PAGES_LARGE; // [RULE2]
        end
        else
        begin
            sector = addr[SECT_LSB_SMALL +: 3]; // [RULE3]
            in_range = addr[15:PAGE_LSB] < PAGES_SMALL; // [RULE2]
        end
        prot_hit = protect[sector]; // [RULE14]
    end

endmodule : fpuc_sector_map

// *** verilog/fpuc_ctrl.sv ***
// Flash controller front end: unlock sequencer, page select, sector protect and overlay.
//
// Contract
// [RULE1] Flash is arranged as 512-byte pages; a page is the least erasable unit.
// [RULE2] Flash is 8192 or 4096 bytes, 16 or 8 pages, from address zero.
// [RULE3] Eight equal sectors, 1024 or 512 bytes, each protectable alone.
// [RULE4] Page select bit 7 overlays the information area on FE00H to FFFFH.
// [RULE5] With overlay on, data loads read the info area; fetches still read flash.
// [RULE6] The information area is read-only; writes to it are ignored.
// [RULE7] A 20-character zero-padded part identifier sits at FE40H to FE53H.
// [RULE8] Frequency high and low bytes form a 16-bit kHz value timing program/erase.
// [RULE9] Software loads frequency first; only 20 kHz to 20 MHz clocks are supported.
// [RULE10] Reset puts the controller in the locked state.
// [RULE11] Program or erase happens only once the controller is unlocked.
// [RULE12] Unlock: 00H, page, 73H, 8CH, same page again.
// [RULE13] Any out-of-order command or page write locks the controller at once; the code keeps a repeated page write in ST_PAGED without locking.
// [RULE14] Sectors with their protect bit set cannot be programmed or erased.
// [RULE15] Reset clears all sector protect bits.
// [RULE16] Writes to sector protect only set bits; zeros change nothing.
// [RULE17] Command 5EH maps sector protect onto the page select address.
// [RULE18] Any other command unmaps it and restores page select.
// [RULE19] The selected sector protect register is read and written at FF9H.
// [RULE20] Read protect option refuses user code to the debug port.
// [RULE21] Write protect option rejects all user program and erase.
// [RULE22] 95H is page erase, 63H mass erase; other or misplaced codes lock. The code never mass erases: 63H only locks.
// [RULE23] Status reports 0 locked, 1 first, 2 second unlock, 3 unlocked, 4 protect selected.
// [RULE24] While unlocked only the unlocked page is programmed; other writes are ignored.
// [RULE25] Writing 00H restarts the unlock sequence from its first step.
`timescale 1ns/1ps
module fpuc_ctrl
    import fpuc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic flash_8k,
    input wire logic opt_read_protect,
    input wire logic opt_write_protect,
    input wire logic mem_rd,
    input wire logic program_memory_load,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic debug_port_rd,
    input wire logic [15:0] debug_port_addr,
    output logic [7:0] debug_port_rdata,
    output logic debug_port_denied,
    output logic [15:0] flash_raddr,
    input wire logic [7:0] flash_rdata,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_prog,
    output logic flash_page_erase,
    output logic [15:0] flash_clock_khz,
    output logic [5:0] controller_state
);

    fpuc_state_t state_r, state_nxt;
    logic [7:0] page_r, page_nxt;
    logic [7:0] prot_r, prot_nxt;
    logic [7:0] freq_hi_r, freq_hi_nxt;
    logic [7:0] freq_lo_r, freq_lo_nxt;
    logic [15:0] faddr_r, faddr_nxt;
    logic [7:0] fwdata_r, fwdata_nxt;
    logic prog_r, prog_nxt;
    logic erase_r, erase_nxt;
    logic [7:0] reg_rdata_r, reg_rdata_nxt;
    logic [7:0] mem_rdata_r, mem_rdata_nxt;
    logic [7:0] dbg_rdata_r, dbg_rdata_nxt;
    logic dbg_denied_r, dbg_denied_nxt;
    logic cmd_wr, page_wr, freq_ok, info_en, mem_info, mem_in_page;
    logic mem_range, mem_prot, pg_range, pg_prot;
    logic [7:0] info_data;
    logic [15:0] page_base;

    // ----------------------------------------
    // Decode and helpers
    // ----------------------------------------
    // Page select and sector protect share one address; the state says which is live.
    assign cmd_wr = reg_wr && reg_addr == ADDR_CMD;
    assign page_wr = reg_wr && reg_addr == ADDR_PAGE;
    assign flash_clock_khz = {freq_hi_r, freq_lo_r}; // [RULE8]
    // Out-of-range frequency would mistime the array, so such operations are dropped.
    assign freq_ok = flash_clock_khz >= FREQ_MIN_KHZ && flash_clock_khz <= FREQ_MAX_KHZ; // [RULE9]
    assign info_en = page_r[INFO_EN_BIT];
    assign mem_info = info_en && mem_addr[15:PAGE_LSB] == INFO_PAGE; // [RULE4]
    assign mem_in_page = mem_addr[15:PAGE_LSB] == page_r[6:0];
    assign page_base = {page_r[6:0], 9'h000}; // [RULE1]
    assign flash_raddr = mem_rd ? mem_addr : debug_port_addr;

    fpuc_sector_map u_mem_sect (
        .addr(mem_addr),
        .flash_8k(flash_8k),
        .protect(prot_r),
        .sector(),
        .in_range(mem_range),
        .prot_hit(mem_prot)
    );

    fpuc_sector_map u_page_sect (
        .addr(page_base),
        .flash_8k(flash_8k),
        .protect(prot_r),
        .sector(),
        .in_range(pg_range),
        .prot_hit(pg_prot)
    );

    fpuc_info_rom u_info (
        .addr(mem_addr[8:0]),
        .data(info_data)
    );

    // ----------------------------------------
    // Status output
    // ----------------------------------------
    // The internal arming steps are still locked as far as software can see.
    always_comb
    begin
        controller_state = 6'h00;
        if (state_r == ST_UNLK1 || state_r == ST_UNLK2 || state_r == ST_OPEN || state_r == ST_SECT)
        begin
            controller_state = {3'b000, state_r}; // [RULE23]
        end
    end

    // ----------------------------------------
    // Sequencer, registers and array strobes: next values
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        page_nxt = page_r;
        prot_nxt = prot_r;
        freq_hi_nxt = freq_hi_r;
        freq_lo_nxt = freq_lo_r;
        faddr_nxt = faddr_r;
        fwdata_nxt = fwdata_r;
        prog_nxt = 1'b0;
        erase_nxt = 1'b0;
        if (cmd_wr)
        begin
            case (reg_wdata)
                CMD_RESET: state_nxt = ST_ARMED; // [RULE25]
                CMD_SECT_SEL: state_nxt = ST_SECT; // [RULE17]
                CMD_UNLOCK1: state_nxt = (state_r == ST_PAGED) ? ST_UNLK1 : ST_LOCK; // [RULE13]
                CMD_UNLOCK2: state_nxt = (state_r == ST_UNLK1) ? ST_UNLK2 : ST_LOCK; // [RULE13]
                CMD_PAGE_ERASE:
                begin
                    // Erase ends the session whether or not it was allowed.
                    state_nxt = ST_LOCK; // [RULE22]
                    if (state_r == ST_OPEN && pg_range && !pg_prot && !opt_write_protect && freq_ok) // [RULE11] [RULE14] [RULE21]
                    begin
                        erase_nxt = 1'b1;
                        faddr_nxt = page_base;
                    end
                end
                // User code may not mass erase; the code only locks.
                CMD_MASS_ERASE: state_nxt = ST_LOCK; // [RULE22]
                default: state_nxt = ST_LOCK; // [RULE18] [RULE22]
            endcase
        end
        else if (page_wr)
        begin
            if (state_r == ST_SECT)
            begin
                prot_nxt = prot_r | reg_wdata; // [RULE16] [RULE19]
            end
            else
            begin
                page_nxt = reg_wdata;
                case (state_r)
                    ST_ARMED: state_nxt = ST_PAGED;
                    ST_PAGED: state_nxt = ST_PAGED;
                    ST_UNLK2: state_nxt = (reg_wdata == page_r) ? ST_OPEN : ST_LOCK; // [RULE12] [RULE13]
                    default: state_nxt = ST_LOCK; // [RULE13]
                endcase
                // A failed match must not move the page that the session named.
                if (state_r == ST_UNLK2 || state_r == ST_OPEN)
                begin
                    page_nxt = page_r;
                end
            end
        end
        else if (reg_wr && reg_addr == ADDR_FREQ_HI)
        begin
            freq_hi_nxt = reg_wdata; // [RULE8]
        end
        else if (reg_wr && reg_addr == ADDR_FREQ_LO)
        begin
            freq_lo_nxt = reg_wdata; // [RULE8]
        end
        // Byte program: silently dropped unless every guard agrees.
        if (mem_wr && state_r == ST_OPEN && mem_in_page && mem_range && !mem_prot && !mem_info
            && !opt_write_protect && freq_ok) // [RULE6] [RULE11] [RULE14] [RULE21] [RULE24]
        begin
            prog_nxt = 1'b1;
            faddr_nxt = mem_addr;
            fwdata_nxt = mem_wdata;
        end
    end

    // Reset locks the controller and forgets any protection. [RULE10] [RULE15]
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_LOCK; // [RULE10]
            page_r <= PAGE_RST;
            prot_r <= PROT_RST; // [RULE15]
            freq_hi_r <= FREQ_RST;
            freq_lo_r <= FREQ_RST;
            faddr_r <= 16'h0000;
            fwdata_r <= 8'hff;
            prog_r <= 1'b0;
            erase_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            page_r <= page_nxt;
            prot_r <= prot_nxt;
            freq_hi_r <= freq_hi_nxt;
            freq_lo_r <= freq_lo_nxt;
            faddr_r <= faddr_nxt;
            fwdata_r <= fwdata_nxt;
            prog_r <= prog_nxt;
            erase_r <= erase_nxt;
        end
    end

    assign flash_addr = faddr_r;
    assign flash_wdata = fwdata_r;
    assign flash_prog = prog_r;
    assign flash_page_erase = erase_r;

    // ----------------------------------------
    // Read paths: next values
    // ----------------------------------------
    // Read data is registered one cycle after the strobe.
    always_comb
    begin
        reg_rdata_nxt = reg_rdata_r;
        mem_rdata_nxt = mem_rdata_r;
        dbg_rdata_nxt = dbg_rdata_r;
        dbg_denied_nxt = 1'b0;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CMD: reg_rdata_nxt = {2'b00, controller_state}; // [RULE23]
                ADDR_PAGE: reg_rdata_nxt = (state_r == ST_SECT) ? prot_r : page_r; // [RULE19]
                ADDR_FREQ_HI: reg_rdata_nxt = freq_hi_r;
                ADDR_FREQ_LO: reg_rdata_nxt = freq_lo_r;
                default: reg_rdata_nxt = 8'h00;
            endcase
        end
        if (mem_rd)
        begin
            // Fetches ignore the overlay so code keeps running from the main array.
            mem_rdata_nxt = (mem_info && program_memory_load) ? info_data : flash_rdata; // [RULE5]
        end
        else if (debug_port_rd)
        begin
            dbg_rdata_nxt = opt_read_protect ? 8'h00 : flash_rdata; // [RULE20]
            dbg_denied_nxt = opt_read_protect; // [RULE20]
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata_r <= 8'h00;
            mem_rdata_r <= 8'h00;
            dbg_rdata_r <= 8'h00;
            dbg_denied_r <= 1'b0;
        end
        else
        begin
            reg_rdata_r <= reg_rdata_nxt;
            mem_rdata_r <= mem_rdata_nxt;
            dbg_rdata_r <= dbg_rdata_nxt;
            dbg_denied_r <= dbg_denied_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign mem_rdata = mem_rdata_r;
    assign debug_port_rdata = dbg_rdata_r;
    assign debug_port_denied = dbg_denied_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_prog_unlocked: assert property (flash_prog |-> $past(state_r) == ST_OPEN) // [RULE11]
        else $error("program strobe without unlocked state");
    a_prog_in_page: assert property (flash_prog |-> flash_addr[15:9] == $past(page_r[6:0])) // [RULE24]
        else $error("program outside the unlocked page");
    a_prog_unprotected: assert property (flash_prog |-> !$past(mem_prot)) // [RULE14]
        else $error("program into a protected sector");
    a_wp_blocks: assert property (opt_write_protect |=> !flash_prog && !flash_page_erase) // [RULE21]
        else $error("operation despite write protect");
    a_prot_sticky: assert property ((($past(prot_r) & ~prot_r) == 8'h00)) // [RULE16]
        else $error("sector protect bit cleared");
    a_bad_cmd_locks: assert property (cmd_wr && reg_wdata != CMD_RESET && reg_wdata != CMD_SECT_SEL
        && !(reg_wdata == CMD_UNLOCK1 && state_r == ST_PAGED)
        && !(reg_wdata == CMD_UNLOCK2 && state_r == ST_UNLK1) |=> controller_state == 6'h00) // [RULE13]
        else $error("misplaced command did not lock");
    a_sect_select: assert property (cmd_wr && reg_wdata == CMD_SECT_SEL |=> controller_state == 6'h04) // [RULE17]
        else $error("protect select not reported");
    a_sect_deselect: assert property (state_r == ST_SECT && cmd_wr && reg_wdata != CMD_SECT_SEL
        |=> state_r != ST_SECT) // [RULE18]
        else $error("protect register still selected");
    a_erase_relocks: assert property (flash_page_erase |-> state_r == ST_LOCK ##1 !flash_page_erase) // [RULE22]
        else $error("erase did not relock");
    a_read_protect: assert property (debug_port_rd && !mem_rd && opt_read_protect
        |=> debug_port_denied && debug_port_rdata == 8'h00) // [RULE20]
        else $error("protected code leaked to debug port");
    a_info_ro: assert property (mem_wr && mem_info |=> !flash_prog) // [RULE6]
        else $error("write reached information area");

    c_unlocked: cover property (state_r == ST_UNLK2 ##1 state_r == ST_OPEN);
    c_program: cover property (flash_prog);
    c_erase: cover property (flash_page_erase);
    c_protect_set: cover property (state_r == ST_SECT && page_wr && reg_wdata != 8'h00);

endmodule : fpuc_ctrl

// *** dv/fpuc_flash_model.sv ***
// Behavioural model of the embedded flash array behind the controller.
`timescale 1ns/1ps
module fpuc_flash_model
    import fpuc_pkg::*;
(
    input wire logic core_clk,
    input wire logic [15:0] flash_raddr,
    output logic [7:0] flash_rdata,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic flash_prog,
    input wire logic flash_page_erase
);
    logic [7:0] mem [0:8191];

    // Seed each byte with a pattern so that an erased cell stands out from a fresh one.
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end

    // Reads are combinational; the 8 KB array aliases higher addresses.
    assign flash_rdata = mem[flash_raddr[12:0]];

    // Programming can only clear bits; erase sets one whole 512-byte page to ff.
    always @(posedge core_clk)
    begin
        if (flash_prog)
            mem[flash_addr[12:0]] <= mem[flash_addr[12:0]] & flash_wdata;
        if (flash_page_erase)
            for (int i = 0; i < PAGE_BYTES; i++)
                mem[{flash_addr[12:9], 9'(i)}] <= 8'hff;
    end
endmodule : fpuc_flash_model

// *** dv/fpuc_ctrl_tb.sv ***
// Self-checking testbench for the flash protect and unlock controller.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) \
        begin \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
            errors++; \
        end \
    end
module fpuc_ctrl_tb
    import fpuc_pkg::*;
;
    logic core_clk, resetn, reg_wr, reg_rd, flash_8k, opt_read_protect, opt_write_protect;
    logic mem_rd, program_memory_load, mem_wr, debug_port_rd, debug_port_denied;
    logic flash_prog, flash_page_erase;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, debug_port_rdata, flash_rdata, flash_wdata;
    logic [15:0] mem_addr, debug_port_addr, flash_raddr, flash_addr, flash_clock_khz;
    logic [5:0] controller_state;
    logic [8:0] off;
    logic [7:0] dat;
    int errors = 0;
    int check_count = 0;

    fpuc_ctrl dut (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flash_8k(flash_8k),
        .opt_read_protect(opt_read_protect), .opt_write_protect(opt_write_protect), .mem_rd(mem_rd),
        .program_memory_load(program_memory_load), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .debug_port_rd(debug_port_rd),
        .debug_port_addr(debug_port_addr), .debug_port_rdata(debug_port_rdata),
        .debug_port_denied(debug_port_denied), .flash_raddr(flash_raddr), .flash_rdata(flash_rdata),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_prog(flash_prog),
        .flash_page_erase(flash_page_erase), .flash_clock_khz(flash_clock_khz),
        .controller_state(controller_state));

    fpuc_flash_model array (.core_clk(core_clk), .flash_raddr(flash_raddr), .flash_rdata(flash_rdata),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_prog(flash_prog),
        .flash_page_erase(flash_page_erase));

    // ----------------------------------------
    // Clock, expectations and bus tasks
    // ----------------------------------------
    // A 100 ns period gives the 10 MHz core clock.
    always #50 core_clk = ~core_clk;

    // Contents the array model starts with, for reads of untouched cells.
    function automatic logic [7:0] init_val(input logic [15:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction : init_val

    // Every task starts and ends 10 ns after an edge, so a strobe is never set twice in one step.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #10 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #10 reg_wr = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [7:0] ex);
        @(posedge core_clk);
        #10 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #10 reg_rd = 1'b0;
        `CHK("reg_rdata", ex, reg_rdata);
    endtask : rdchk

    task automatic unlock(input logic [7:0] p);
        wr(ADDR_CMD, CMD_RESET);
        wr(ADDR_PAGE, p);
        wr(ADDR_CMD, CMD_UNLOCK1);
        wr(ADDR_CMD, CMD_UNLOCK2);
        wr(ADDR_PAGE, p);
    endtask : unlock

    // The program pulse must appear, with address and data, in the cycle after the request.
    task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic ex);
        @(posedge core_clk);
        #10 mem_wr = 1'b1;
        mem_addr = a;
        mem_wdata = d;
        @(posedge core_clk);
        #10 mem_wr = 1'b0;
        `CHK("flash_prog", ex, flash_prog);
        if (ex)
        begin
            `CHK("flash_addr", a, flash_addr);
            `CHK("flash_wdata", d, flash_wdata);
        end
    endtask : prog

    task automatic memrd(input logic [15:0] a, input logic load, input logic [7:0] ex);
        @(posedge core_clk);
        #10 mem_rd = 1'b1;
        mem_addr = a;
        program_memory_load = load;
        @(posedge core_clk);
        #10 mem_rd = 1'b0;
        `CHK("mem_rdata", ex, mem_rdata);
    endtask : memrd

    task automatic dbg(input logic [15:0] a, input logic [7:0] ex, input logic den);
        @(posedge core_clk);
        #10 debug_port_rd = 1'b1;
        debug_port_addr = a;
        @(posedge core_clk);
        #10 debug_port_rd = 1'b0;
        `CHK("debug_port_rdata", ex, debug_port_rdata);
        `CHK("debug_port_denied", den, debug_port_denied);
    endtask : dbg

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {core_clk, resetn, reg_wr, reg_rd, opt_read_protect, opt_write_protect} = '0;
        {mem_rd, program_memory_load, mem_wr, debug_port_rd} = '0;
        {reg_addr, reg_wdata, mem_addr, mem_wdata, debug_port_addr} = '0;
        flash_8k = 1'b1;
        void'($urandom(56383));
        repeat (3) @(posedge core_clk);
        #10 resetn = 1'b1;
        `CHK("state", 6'h00, controller_state);
        `CHK("flash_wdata", 8'hff, flash_wdata);
        rdchk(ADDR_CMD, 8'h00);
        unlock(8'h02);
        prog(16'h0410, 8'h0f, 1'b0);
        wr(ADDR_CMD, CMD_MASS_ERASE);
        wr(ADDR_FREQ_HI, 8'h27);
        wr(ADDR_FREQ_LO, 8'h10);
        `CHK("flash_clock_khz", 16'h2710, flash_clock_khz);
        prog(16'h0410, 8'h0f, 1'b0);
        // Walk the unlock steps and watch the reported status after the 73H, 8CH and second page writes.
        wr(ADDR_CMD, CMD_RESET);
        wr(ADDR_PAGE, 8'h02);
        wr(ADDR_CMD, CMD_UNLOCK1);
        rdchk(ADDR_CMD, 8'h01);
        wr(ADDR_CMD, CMD_UNLOCK2);
        rdchk(ADDR_CMD, 8'h02);
        wr(ADDR_PAGE, 8'h02);
        rdchk(ADDR_CMD, 8'h03);
        prog(16'h0410, 8'h0f, 1'b1);
        prog(16'h0610, 8'h00, 1'b0);
        memrd(16'h0410, 1'b0, init_val(16'h0410) & 8'h0f);
        // Random bytes anywhere inside the unlocked page must all be programmed.
        repeat (6)
        begin
            off = 9'($urandom);
            dat = 8'($urandom);
            prog({7'h02, off}, dat, 1'b1);
        end
        wr(ADDR_CMD, CMD_PAGE_ERASE);
        `CHK("flash_page_erase", 1'b1, flash_page_erase);
        `CHK("erase_addr", 16'h0400, flash_addr);
        `CHK("state", 6'h00, controller_state);
        memrd(16'h0410, 1'b0, 8'hff);
        // Out-of-order writes, a restart in mid-sequence and foreign codes.
        wr(ADDR_CMD, CMD_RESET);
        wr(ADDR_CMD, CMD_UNLOCK1);
        `CHK("state", 6'h00, controller_state);
        wr(ADDR_CMD, CMD_RESET);
        wr(ADDR_PAGE, 8'h03);
        wr(ADDR_CMD, CMD_UNLOCK1);
        wr(ADDR_CMD, CMD_UNLOCK2);
        wr(ADDR_PAGE, 8'h04);
        `CHK("state", 6'h00, controller_state);
        wr(ADDR_CMD, CMD_RESET);
        wr(ADDR_PAGE, 8'h03);
        wr(ADDR_CMD, CMD_UNLOCK1);
        unlock(8'h03);
        `CHK("state", 6'h03, controller_state);
        wr(ADDR_CMD, CMD_MASS_ERASE);
        `CHK("state", 6'h00, controller_state);
        `CHK("flash_page_erase", 1'b0, flash_page_erase);
        unlock(8'h03);
        wr(ADDR_CMD, 8'h11);
        `CHK("state", 6'h00, controller_state);
        // Sector protect: set-only writes, then a protected and an unprotected sector.
        wr(ADDR_CMD, CMD_SECT_SEL);
        `CHK("state", 6'h04, controller_state);
        rdchk(ADDR_PAGE, 8'h00);
        wr(ADDR_PAGE, 8'h05);
        wr(ADDR_PAGE, 8'h02);
        wr(ADDR_PAGE, 8'h00);
        rdchk(ADDR_PAGE, 8'h07);
        unlock(8'h03);
        prog(16'h0600, 8'h00, 1'b0);
        wr(ADDR_CMD, CMD_PAGE_ERASE);
        `CHK("flash_page_erase", 1'b0, flash_page_erase);
        unlock(8'h06);
        prog(16'h0c00, 8'h00, 1'b1);
        opt_write_protect = 1'b1;
        prog(16'h0c01, 8'h00, 1'b0);
        opt_write_protect = 1'b0;
        // The small variant has eight pages and 512-byte sectors.
        flash_8k = 1'b0;
        unlock(8'h03);
        prog(16'h0600, 8'h00, 1'b1);
        unlock(8'h09);
        prog(16'h1200, 8'h00, 1'b0);
        flash_8k = 1'b1;
        // Information area overlay: loads see the identifier, fetches see the array.
        wr(ADDR_CMD, CMD_RESET);
        wr(ADDR_PAGE, 8'h80);
        rdchk(ADDR_PAGE, 8'h80);
        memrd(16'hfe40, 1'b1, 8'h4e);
        memrd(16'hfe4b, 1'b1, 8'h30);
        memrd(16'hfe4c, 1'b1, 8'h00);
        memrd(16'hfe00, 1'b1, 8'h00);
        memrd(16'hfe40, 1'b0, init_val(16'hfe40));
        unlock(8'hff);
        prog(16'hfe40, 8'h00, 1'b0);
        // Debug reads return array data unless read protection is on.
        dbg(16'h0100, init_val(16'h0100), 1'b0);
        opt_read_protect = 1'b1;
        dbg(16'h0100, 8'h00, 1'b1);
        wrap_up();
    end

    // A hung sequence counts as a mismatch and still reaches the verdict.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        wrap_up();
    end
endmodule : fpuc_ctrl_tb
